//--- shared/dcd_defines.vh
`ifndef DCD_DEFINES_VH
`define DCD_DEFINES_VH

// Clock period of clk_sys_i in picoseconds (125 MHz).
`define DCD_CLK_PS          8000

// Raw command kinds seen on CS#, RAS#, CAS#, WE# before the clock enable is weighed.
`define DCD_KIND_NOP        3'h0
`define DCD_KIND_MRS        3'h1
`define DCD_KIND_REF        3'h2
`define DCD_KIND_PRE        3'h3
`define DCD_KIND_ACT        3'h4
`define DCD_KIND_WR         3'h5
`define DCD_KIND_RD         3'h6
`define DCD_KIND_ZQ         3'h7

// Resolved command codes reported on cmd_code_o.
`define DCD_CMD_NONE        4'h0
`define DCD_CMD_MRS         4'h1
`define DCD_CMD_REF         4'h2
`define DCD_CMD_PRE         4'h3
`define DCD_CMD_PRECHARGE_EVERY_BANK        4'h4
`define DCD_CMD_ACT         4'h5
`define DCD_CMD_WR          4'h6
`define DCD_CMD_RD          4'h7
`define DCD_CMD_IMPEDANCE_CAL_LONG        4'h8
`define DCD_CMD_IMPEDANCE_CAL_SHORT        4'h9
`define DCD_CMD_SRE         4'hA
`define DCD_CMD_PDE         4'hB
`define DCD_CMD_PDX         4'hC
`define DCD_CMD_SRX         4'hD

// Address field positions.
`define DCD_A10             10
`define DCD_A12             12

// Organisation select on cfg_org_i.
`define DCD_ORG_X4          2'h0
`define DCD_ORG_X8          2'h1
`define DCD_ORG_X16         2'h2

// Burst mode field of mode register 0 (address bits 1:0).
`define DCD_BURST_EIGHT_FIXED 2'h0
`define DCD_BURST_ON_THE_FLY  2'h1
`define DCD_CHOP_FOUR_FIXED   2'h2
`define DCD_BURST_MODE_RESET  2'h0

// Clocks a burst keeps the data path busy, for full and chopped bursts alike.
`define DCD_BURST_CYC       4'h4

// Internal busy times in nanoseconds and the derived clock counts (rounded up).
`define DCD_PRECHARGE_NS    15
`define DCD_REFRESH_NS      260
`define DCD_PD_EXIT_NS      6
`define DCD_SR_EXIT_NS      270
`define DCD_PRECHARGE_CYC   ((`DCD_PRECHARGE_NS * 1000 + `DCD_CLK_PS - 1) / `DCD_CLK_PS)
`define DCD_REFRESH_CYC     ((`DCD_REFRESH_NS * 1000 + `DCD_CLK_PS - 1) / `DCD_CLK_PS)
`define DCD_PD_EXIT_CYC     ((`DCD_PD_EXIT_NS * 1000 + `DCD_CLK_PS - 1) / `DCD_CLK_PS)
`define DCD_SR_EXIT_CYC     ((`DCD_SR_EXIT_NS * 1000 + `DCD_CLK_PS - 1) / `DCD_CLK_PS)

`endif

//--- src/dcd_cmd_classify.v
`include "dcd_defines.vh"

// Turns the four command strobes into a raw command kind.
module dcd_cmd_classify (
	input  wire       cs_n_i,  // Chip select, active low.
	input  wire       ras_n_i, // Row strobe, active low.
	input  wire       cas_n_i, // Column strobe, active low.
	input  wire       we_n_i,  // Write enable, active low.
	output reg  [2:0] kind_o   // Raw command kind.
);

	////////////////////////////////////////////////////////////////////////////////
	// A deselected device sees a no-operation whatever the other strobes carry.
	always @* begin
		kind_o = `DCD_KIND_NOP;
		if (!cs_n_i) begin
			case ({ras_n_i, cas_n_i, we_n_i})
				3'h0: kind_o = `DCD_KIND_MRS;
				3'h1: kind_o = `DCD_KIND_REF;
				3'h2: kind_o = `DCD_KIND_PRE;
				3'h3: kind_o = `DCD_KIND_ACT;
				3'h4: kind_o = `DCD_KIND_WR;
				3'h5: kind_o = `DCD_KIND_RD;
				3'h6: kind_o = `DCD_KIND_ZQ;
				default: kind_o = `DCD_KIND_NOP;
			endcase
		end
	end

endmodule

//--- src/dcd_bank_tracker.v
`include "dcd_defines.vh"

// Keeps the open-bank map and the busy times of bursts, precharges and refreshes.
module dcd_bank_tracker (
	input  wire       clk_sys_i,   // System clock.
	input  wire       rst_i,       // Synchronous reset, active high.
	input  wire       reset_n_i,   // Asynchronous device reset, active low.
	input  wire       cmd_valid_i, // Registered command pulse.
	input  wire [3:0] cmd_code_i,  // Registered command code.
	input  wire [2:0] cmd_bank_i,  // Registered bank address.
	input  wire       auto_pre_i,  // Auto precharge with a read or write.
	output reg  [7:0] banks_open_o, // One bit per open bank.
	output wire       burst_busy_o, // A burst is running.
	output wire       precharging_o, // A precharge is running.
	output wire       refreshing_o  // A refresh is running.
);

	localparam integer PRE_FULL = `DCD_PRECHARGE_CYC;
	localparam integer REF_FULL = `DCD_REFRESH_CYC;
	localparam [7:0]   PRE_CYC  = PRE_FULL[7:0];
	localparam [7:0]   REF_CYC  = REF_FULL[7:0];

	reg  [3:0] burst_cnt;
	reg  [7:0] ap_pend;
	reg  [7:0] pre_cnt;
	reg  [7:0] ref_cnt;
	wire       is_rdwr;
	wire       burst_end;
	wire [4:0] burst_sum;

	assign is_rdwr       = cmd_valid_i && (cmd_code_i == `DCD_CMD_RD || cmd_code_i == `DCD_CMD_WR);
	assign burst_end     = (burst_cnt == 4'h1) && !is_rdwr;
	assign burst_sum     = {1'b0, burst_cnt} + {1'b0, `DCD_BURST_CYC};
	assign burst_busy_o  = (burst_cnt != 4'h0);
	assign precharging_o = (pre_cnt != 8'h00);
	assign refreshing_o  = (ref_cnt != 8'h00);

	////////////////////////////////////////////////////////////////////////////////
	// A new read or write is appended behind the running burst, never cutting it short.
	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			burst_cnt    <= 4'h0;
			ap_pend      <= 8'h00;
			pre_cnt      <= 8'h00;
			ref_cnt      <= 8'h00;
			banks_open_o <= 8'h00;
		end else if (rst_i) begin
			burst_cnt    <= 4'h0;
			ap_pend      <= 8'h00;
			pre_cnt      <= 8'h00;
			ref_cnt      <= 8'h00;
			banks_open_o <= 8'h00;
		end else begin
			if (is_rdwr) begin
				burst_cnt <= burst_sum[4] ? 4'hF : (burst_sum[3:0] - 4'h1);
				if (auto_pre_i) begin
					ap_pend[cmd_bank_i] <= 1'b1;
				end
			end else if (burst_cnt != 4'h0) begin
				burst_cnt <= burst_cnt - 4'h1;
			end
			if (ref_cnt != 8'h00) begin
				ref_cnt <= ref_cnt - 8'h01;
			end
			if (pre_cnt != 8'h00) begin
				pre_cnt <= pre_cnt - 8'h01;
			end
			// Auto precharge closes its banks when the last burst has left.
			if (burst_end && ap_pend != 8'h00) begin
				banks_open_o <= banks_open_o & ~ap_pend;
				ap_pend      <= 8'h00;
				pre_cnt      <= PRE_CYC;
			end
			if (cmd_valid_i) begin
				case (cmd_code_i)
					`DCD_CMD_ACT: banks_open_o[cmd_bank_i] <= 1'b1;
					`DCD_CMD_PRE: begin
						if (banks_open_o[cmd_bank_i]) begin
							banks_open_o[cmd_bank_i] <= 1'b0;
							pre_cnt                  <= PRE_CYC;
						end
					end
					`DCD_CMD_PRECHARGE_EVERY_BANK: begin
						banks_open_o <= 8'h00;
						pre_cnt      <= PRE_CYC;
					end
					`DCD_CMD_REF: ref_cnt <= REF_CYC;
					default: ;
				endcase
			end
		end
	end

endmodule

//--- src/dcd_cmd_decoder.v

`include "dcd_defines.vh"

module dcd_cmd_decoder (
	input  wire        clk_sys_i,      // System clock, 125 MHz.
	input  wire        rst_i,          // Synchronous reset, active high.
	input  wire        reset_n_i,      // Device reset pin, asynchronous, active low.
	input  wire        cke_i,          // Clock enable.
	input  wire        cs_n_i,         // Chip select, active low.
	input  wire        ras_n_i,        // Row strobe, active low.
	input  wire        cas_n_i,        // Column strobe, active low.
	input  wire        we_n_i,         // Write enable, active low.
	input  wire        odt_i,          // Termination control, not used by decode.
	input  wire [2:0]  ba_i,           // Bank address.
	input  wire [15:0] addr_i,         // Address bus.
	input  wire [1:0]  cfg_org_i,      // Data-width organisation.
	output reg         cmd_valid_o,    // One-cycle pulse with each decoded command.
	output reg  [3:0]  cmd_code_o,     // Decoded command code.
	output reg  [2:0]  cmd_bank_o,     // Bank, or mode register select in bits 1:0.
	output reg  [15:0] cmd_row_o,      // Row address trimmed to the organisation.
	output reg  [10:0] cmd_col_o,      // Column address trimmed to the organisation.
	output reg  [15:0] cmd_opcode_o,   // Raw address, the opcode of a mode-register set.
	output reg         auto_pre_o,     // Read or write with auto precharge.
	output reg         chop_o,         // Read or write is a chopped burst of four.
	output reg         illegal_o,      // One-cycle pulse on an unlisted sequence.
	output reg  [3:0]  power_state_o,  // One-hot power state.
	output reg  [1:0]  burst_mode_o,   // Burst mode held from mode register 0.
	output wire        self_refresh_o, // Self refresh in force.
	output wire        idle_o,         // All banks idle.
	output wire [7:0]  banks_open_o,   // One bit per open bank.
	output wire        burst_busy_o    // A burst is running.
);

	////////////////////////////////////////////////////////////////////////////////
	// Power states and timing counts.

	localparam [3:0] ST_ON     = 4'h1;
	localparam [3:0] ST_PD_PRE = 4'h2;
	localparam [3:0] ST_PD_ACT = 4'h4;
	localparam [3:0] ST_SELF   = 4'h8;

	// Exit counts are worked out as integers, then cut to the width of the exit counter.
	localparam integer PD_EXIT_FULL = `DCD_PD_EXIT_CYC;
	localparam integer SR_EXIT_FULL = `DCD_SR_EXIT_CYC;
	localparam [7:0]   PD_EXIT_CYC  = PD_EXIT_FULL[7:0];
	localparam [7:0]   SR_EXIT_CYC  = SR_EXIT_FULL[7:0];

	////////////////////////////////////////////////////////////////////////////////
	// Address field trimming per organisation.

	// The x16 part has one row bit fewer than the narrower parts.
	function [15:0] dcd_row_field;
		input [1:0]  org;
		input [15:0] addr;
		begin
			if (org == `DCD_ORG_X16) begin
				dcd_row_field = addr & 16'h7FFF;
			end else begin
				dcd_row_field = addr;
			end
		end
	endfunction

	// Only the x4 part uses A11 as its top column bit; A10 is never a column bit.
	function [10:0] dcd_col_field;
		input [1:0]  org;
		input [15:0] addr;
		begin
			if (org == `DCD_ORG_X4) begin
				dcd_col_field = {addr[11], addr[9:0]};
			end else begin
				dcd_col_field = {1'b0, addr[9:0]};
			end
		end
	endfunction

	// Chop decision from the held burst mode and A12 of the command.
	function dcd_chop;
		input [1:0] mode;
		input       a12;
		begin
			if (mode == `DCD_BURST_ON_THE_FLY) begin
				dcd_chop = ~a12;
			end else begin
				dcd_chop = (mode == `DCD_CHOP_FOUR_FIXED);
			end
		end
	endfunction

	// Banks all closed, no burst, precharge or refresh running, and no exit time left.
	function dcd_bank_quiet;
		input [7:0] banks;
		input       busy;
		input       pre;
		input       refr;
		input [7:0] exit_left;
		begin
			dcd_bank_quiet = (banks == 8'h00) && !busy && !pre && !refr && (exit_left == 8'h00);
		end
	endfunction

	// A read or a write, the two commands that start a burst.
	function dcd_is_rdwr;
		input [3:0] code;
		begin
			dcd_is_rdwr = (code == `DCD_CMD_RD) || (code == `DCD_CMD_WR);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Signals.

	reg        cke_prev;
	reg  [3:0] state;
	reg  [7:0] exit_cnt;
	reg  [3:0] next_state;
	reg  [3:0] next_code;
	reg        next_illegal;
	reg  [7:0] next_exit_cnt;
	wire [2:0] kind;
	wire       kind_nop;
	wire       precharging;
	wire       refreshing;
	wire       next_valid;

	////////////////////////////////////////////////////////////////////////////////
	// Raw command classification and bank bookkeeping.

	dcd_cmd_classify u_classify (
		.cs_n_i  (cs_n_i),
		.ras_n_i (ras_n_i),
		.cas_n_i (cas_n_i),
		.we_n_i  (we_n_i),
		.kind_o  (kind)
	);

	dcd_bank_tracker u_tracker (
		.clk_sys_i     (clk_sys_i),
		.rst_i         (rst_i),
		.reset_n_i     (reset_n_i),
		.cmd_valid_i   (cmd_valid_o),
		.cmd_code_i    (cmd_code_o),
		.cmd_bank_i    (cmd_bank_o),
		.auto_pre_i    (auto_pre_o),
		.banks_open_o  (banks_open_o),
		.burst_busy_o  (burst_busy_o),
		.precharging_o (precharging),
		.refreshing_o  (refreshing)
	);

	// Deselect and no-operation both arrive here as the no-operation kind.
	assign kind_nop = (kind == `DCD_KIND_NOP);

	// Idle needs the enable high on both edges, closed banks and no busy time left.
	assign idle_o = (state == ST_ON) && cke_prev && cke_i
		&& dcd_bank_quiet(banks_open_o, burst_busy_o, precharging, refreshing, exit_cnt);

	// The enable returning high ends self refresh without waiting for an edge.
	assign self_refresh_o = (state == ST_SELF) && !cke_i;

	assign next_valid = (next_code != `DCD_CMD_NONE);

	////////////////////////////////////////////////////////////////////////////////
	// Command and power-state decode; the termination input is not looked at here.
	always @* begin
		next_state    = state;
		next_code     = `DCD_CMD_NONE;
		next_illegal  = 1'b0;
		next_exit_cnt = (exit_cnt != 8'h00) ? (exit_cnt - 8'h01) : 8'h00;
		case (state)
			ST_ON: begin
				if (cke_prev && cke_i) begin
					case (kind)
						`DCD_KIND_MRS: next_code = `DCD_CMD_MRS;
						`DCD_KIND_REF: next_code = `DCD_CMD_REF;
						`DCD_KIND_PRE: next_code = addr_i[`DCD_A10] ? `DCD_CMD_PRECHARGE_EVERY_BANK : `DCD_CMD_PRE;
						`DCD_KIND_ACT: next_code = `DCD_CMD_ACT;
						`DCD_KIND_WR:  next_code = `DCD_CMD_WR;
						`DCD_KIND_RD:  next_code = `DCD_CMD_RD;
						`DCD_KIND_ZQ:  next_code = addr_i[`DCD_A10] ? `DCD_CMD_IMPEDANCE_CAL_LONG : `DCD_CMD_IMPEDANCE_CAL_SHORT;
						default:       next_code = `DCD_CMD_NONE;
					endcase
				end else if (cke_prev && !cke_i) begin
					// Idle is judged on the state just before this edge, the falling enable aside.
					if (kind == `DCD_KIND_REF
						&& dcd_bank_quiet(banks_open_o, burst_busy_o, precharging, refreshing, exit_cnt)) begin
						next_state = ST_SELF;
						next_code  = `DCD_CMD_SRE;
					end else begin
						// Any other command with a falling enable, save a no-operation, is flagged, then handled as no-operation.
						next_illegal = !kind_nop;
						next_code    = `DCD_CMD_PDE;
						if (banks_open_o != 8'h00) begin
							next_state = ST_PD_ACT;
						end else begin
							next_state = ST_PD_PRE;
						end
					end
				end
			end
			ST_PD_PRE, ST_PD_ACT: begin
				if (!cke_prev && cke_i) begin
					next_state    = ST_ON;
					next_code     = `DCD_CMD_PDX;
					next_illegal  = !kind_nop;
					next_exit_cnt = PD_EXIT_CYC;
				end
			end
			ST_SELF: begin
				// The enable alone ends self refresh; its level at the previous edge was low.
				if (cke_i) begin
					next_state    = ST_ON;
					next_code     = `DCD_CMD_SRX;
					next_illegal  = !kind_nop;
					next_exit_cnt = SR_EXIT_CYC;
				end
			end
			default: begin
				next_state = ST_ON;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// State, enable history and registered command outputs; the device reset is asynchronous.
	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cke_prev      <= 1'b0;
			state         <= ST_ON;
			exit_cnt      <= 8'h00;
			cmd_valid_o   <= 1'b0;
			cmd_code_o    <= `DCD_CMD_NONE;
			cmd_bank_o    <= 3'h0;
			cmd_row_o     <= 16'h0000;
			cmd_col_o     <= 11'h000;
			cmd_opcode_o  <= 16'h0000;
			auto_pre_o    <= 1'b0;
			chop_o        <= 1'b0;
			illegal_o     <= 1'b0;
			power_state_o <= ST_ON;
			burst_mode_o  <= `DCD_BURST_MODE_RESET;
		end else if (rst_i) begin
			cke_prev      <= 1'b0;
			state         <= ST_ON;
			exit_cnt      <= 8'h00;
			cmd_valid_o   <= 1'b0;
			cmd_code_o    <= `DCD_CMD_NONE;
			cmd_bank_o    <= 3'h0;
			cmd_row_o     <= 16'h0000;
			cmd_col_o     <= 11'h000;
			cmd_opcode_o  <= 16'h0000;
			auto_pre_o    <= 1'b0;
			chop_o        <= 1'b0;
			illegal_o     <= 1'b0;
			power_state_o <= ST_ON;
			burst_mode_o  <= `DCD_BURST_MODE_RESET;
		end else begin
			cke_prev      <= cke_i;
			state         <= next_state;
			power_state_o <= next_state;
			exit_cnt      <= next_exit_cnt;
			cmd_valid_o   <= next_valid;
			cmd_code_o    <= next_code;
			illegal_o     <= next_illegal;
			// Address fields only move when a command code is reported, so a no-operation changes nothing unless the enable changes.
			if (next_valid) begin
				cmd_bank_o   <= ba_i;
				cmd_row_o    <= dcd_row_field(cfg_org_i, addr_i);
				cmd_col_o    <= dcd_col_field(cfg_org_i, addr_i);
				cmd_opcode_o <= addr_i;
				auto_pre_o   <= dcd_is_rdwr(next_code) && addr_i[`DCD_A10];
				chop_o       <= dcd_is_rdwr(next_code) && dcd_chop(burst_mode_o, addr_i[`DCD_A12]);
			end
			// Mode register 0 holds the burst mode that steers chop decoding.
			if (next_code == `DCD_CMD_MRS && ba_i == 3'h0) begin
				burst_mode_o <= addr_i[1:0];
			end
		end
	end

endmodule

//--- verification/dcd_cmd_decoder_sva.sv
`include "dcd_defines.vh"

// Watches the decoder ports for decode and power-state relations.
module dcd_cmd_decoder_sva (
	input wire        clk_sys_i,      // System clock.
	input wire        rst_i,          // Synchronous reset.
	input wire        reset_n_i,      // Device reset, active low.
	input wire        cke_i,          // Clock enable.
	input wire        cs_n_i,         // Chip select.
	input wire        ras_n_i,        // Row strobe.
	input wire        cas_n_i,        // Column strobe.
	input wire        we_n_i,         // Write enable.
	input wire [2:0]  ba_i,           // Bank address.
	input wire [15:0] addr_i,         // Address bus.
	input wire        cmd_valid_o,    // Command pulse.
	input wire [3:0]  cmd_code_o,     // Command code.
	input wire [2:0]  cmd_bank_o,     // Command bank.
	input wire [15:0] cmd_opcode_o,   // Raw address.
	input wire        auto_pre_o,     // Auto precharge.
	input wire [3:0]  power_state_o,  // Power state.
	input wire        self_refresh_o, // Self refresh.
	input wire [7:0]  banks_open_o    // Open banks.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       cke_prev;
	wire        pwr_on = power_state_o == 4'h1;
	wire [2:0]  strobes = {ras_n_i, cas_n_i, we_n_i};
	wire        take = cke_prev && cke_i && pwr_on && !cs_n_i;
	wire        quiet = cs_n_i || (strobes == 3'h7);

	// Clock enable seen at the previous edge, cleared by either reset.
	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			cke_prev <= 1'b0;
		else
			cke_prev <= rst_i ? 1'b0 : cke_i;
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i || !reset_n_i);

	a_take_valid: assert property (take && strobes != 3'h7 |=> cmd_valid_o)
		else $error("Command was not answered.");
	a_quiet_none: assert property (cke_prev && cke_i && pwr_on && quiet |=> !cmd_valid_o)
		else $error("Command reported for a no-operation.");
	a_act_bank: assert property (take && strobes == 3'h3 |=>
		cmd_code_o == `DCD_CMD_ACT && cmd_bank_o == $past(ba_i))
		else $error("Activate decoded wrongly.");
	a_pre_scope: assert property (take && strobes == 3'h2 |=>
		cmd_code_o == ($past(addr_i[10]) ? `DCD_CMD_PRECHARGE_EVERY_BANK : `DCD_CMD_PRE))
		else $error("Precharge scope wrong.");
	a_zq_length: assert property (take && strobes == 3'h6 |=>
		cmd_code_o == ($past(addr_i[10]) ? `DCD_CMD_IMPEDANCE_CAL_LONG : `DCD_CMD_IMPEDANCE_CAL_SHORT))
		else $error("Calibration length wrong.");
	a_mrs_opcode: assert property (take && strobes == 3'h0 |=>
		cmd_code_o == `DCD_CMD_MRS && cmd_opcode_o == $past(addr_i))
		else $error("Mode register set decoded wrongly.");
	a_rw_autopre: assert property (take && strobes[2:1] == 2'h2 |=> auto_pre_o == $past(addr_i[10])
		&& cmd_code_o == ($past(we_n_i) ? `DCD_CMD_RD : `DCD_CMD_WR))
		else $error("Read or write decoded wrongly.");
	a_lowpwr_hold: assert property (!pwr_on && !cke_prev && !cke_i |=> $stable(power_state_o))
		else $error("Low-power state left with enable low.");
	a_pd_exit: assert property ((power_state_o == 4'h2 || power_state_o == 4'h4) && !cke_prev && cke_i && quiet
		|=> power_state_o == 4'h1 && cmd_code_o == `DCD_CMD_PDX)
		else $error("Power-down exit missed.");
	a_sr_async: assert property (power_state_o == 4'h8 |-> self_refresh_o == !cke_i)
		else $error("Self refresh flag does not follow the enable.");
	a_pd_active: assert property (pwr_on && cke_prev && !cke_i && quiet && banks_open_o != 8'h00
		|=> power_state_o == 4'h4)
		else $error("Active power-down not entered.");
	a_async_reset: assert property (disable iff (rst_i) !reset_n_i |->
		power_state_o == 4'h1 && !cmd_valid_o && banks_open_o == 8'h00)
		else $error("Device reset not in force.");

	c_sr_entry: cover property (cmd_valid_o && cmd_code_o == `DCD_CMD_SRE);
	c_pd_exit: cover property (cmd_valid_o && cmd_code_o == `DCD_CMD_PDX);
	c_precharge_every_bank: cover property (cmd_valid_o && cmd_code_o == `DCD_CMD_PRECHARGE_EVERY_BANK);
endmodule

bind dcd_cmd_decoder dcd_cmd_decoder_sva dcd_cmd_decoder_sva_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
	.reset_n_i(reset_n_i), .cke_i(cke_i), .cs_n_i(cs_n_i), .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i),
	.ba_i(ba_i), .addr_i(addr_i), .cmd_valid_o(cmd_valid_o), .cmd_code_o(cmd_code_o), .cmd_bank_o(cmd_bank_o),
	.cmd_opcode_o(cmd_opcode_o), .auto_pre_o(auto_pre_o), .power_state_o(power_state_o),
	.self_refresh_o(self_refresh_o), .banks_open_o(banks_open_o));

//--- verification/dcd_ctrl_model.sv
// Memory controller model that drives the command pins at falling edges.
module dcd_ctrl_model (
	input  wire         clk_sys_i, // System clock.
	output logic        cke_o,     // Clock enable.
	output logic        cs_n_o,    // Chip select, active low.
	output logic [2:0]  cmd_n_o,   // Row, column and write strobes.
	output logic        odt_o,     // Termination control.
	output logic [2:0]  ba_o,      // Bank address.
	output logic [15:0] addr_o     // Address bus.
);
	timeunit 1ns;
	timeprecision 1ps;

	// Pins start deselected with the enable high, so the first command waits two edges.
	initial begin
		cke_o = 1'b1;
		cs_n_o = 1'b1;
		cmd_n_o = 3'h7;
		odt_o = 1'b0;
		ba_o = 3'h0;
		addr_o = 16'h0000;
	end

	// Drives one listed command with defined levels; termination toggles freely.
	task automatic send(input logic k, input logic [2:0] s, input logic [2:0] b, input logic [15:0] a);
		@(negedge clk_sys_i);
		cke_o = k;
		cs_n_o = 1'b0;
		cmd_n_o = s;
		ba_o = b;
		addr_o = a;
		odt_o = ~odt_o;
	endtask

	// A no-operation under the given enable; the valid-marked fields move but stay at defined levels.
	task automatic nop_cmd(input logic k);
		send(k, 3'h7, ~ba_o, ~addr_o);
	endtask

	// Deselects; released lines flip each cycle and the enable is held as last set.
	task automatic nop(input int n);
		repeat (n) begin
			@(negedge clk_sys_i);
			cs_n_o = 1'b1;
			cmd_n_o = ~cmd_n_o;
			ba_o = ~ba_o;
			addr_o = ~addr_o;
			odt_o = ~odt_o;
		end
	endtask
endmodule

//--- verification/tb_top.sv
`include "dcd_defines.vh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys_i, rst_i, reset_n_i;
	logic [1:0]  cfg_org_i;
	wire         cke, cs_n, odt, cmd_valid_o, auto_pre_o, chop_o, self_refresh_o, idle_o, burst_busy_o, illegal_o;
	wire [2:0]   cmd_n, ba, cmd_bank_o;
	wire [15:0]  addr, cmd_row_o, cmd_opcode_o;
	wire [10:0]  cmd_col_o;
	wire [3:0]   cmd_code_o, power_state_o;
	wire [1:0]   burst_mode_o;
	wire [7:0]   banks_open_o;
	int          n_fail, total_checks, cycles, bnk;
	localparam logic [2:0] ks [12] = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h2, 3'h3, 3'h5, 3'h3, 3'h2, 3'h6, 3'h6, 3'h1};
	localparam logic [15:0] ka [12] = '{16'h0001, 16'h0000, 16'h0000, 16'h1000, 16'h0400, 16'h0000, 16'h1400,
		16'h0000, 16'h0000, 16'h0400, 16'h0000, 16'h0000};
	localparam logic [3:0] kc [12] = '{`DCD_CMD_MRS, `DCD_CMD_ACT, `DCD_CMD_WR, `DCD_CMD_RD, `DCD_CMD_PRECHARGE_EVERY_BANK,
		`DCD_CMD_ACT, `DCD_CMD_RD, `DCD_CMD_ACT, `DCD_CMD_PRE, `DCD_CMD_IMPEDANCE_CAL_LONG, `DCD_CMD_IMPEDANCE_CAL_SHORT, `DCD_CMD_REF};

	// Free-running 125 MHz clock.
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end

	dcd_ctrl_model dcd_ctrl_model_inst (.clk_sys_i(clk_sys_i), .cke_o(cke), .cs_n_o(cs_n), .cmd_n_o(cmd_n),
		.odt_o(odt), .ba_o(ba), .addr_o(addr));
	dcd_cmd_decoder dcd_cmd_decoder_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reset_n_i(reset_n_i),
		.cke_i(cke), .cs_n_i(cs_n), .ras_n_i(cmd_n[2]), .cas_n_i(cmd_n[1]), .we_n_i(cmd_n[0]), .odt_i(odt),
		.ba_i(ba), .addr_i(addr), .cfg_org_i(cfg_org_i), .cmd_valid_o(cmd_valid_o), .cmd_code_o(cmd_code_o),
		.cmd_bank_o(cmd_bank_o), .cmd_row_o(cmd_row_o), .cmd_col_o(cmd_col_o), .cmd_opcode_o(cmd_opcode_o),
		.auto_pre_o(auto_pre_o), .chop_o(chop_o), .illegal_o(illegal_o), .power_state_o(power_state_o),
		.burst_mode_o(burst_mode_o), .self_refresh_o(self_refresh_o), .idle_o(idle_o),
		.banks_open_o(banks_open_o), .burst_busy_o(burst_busy_o));

	////////////////////////////////////////////////////////////////////////////////

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task complete_run;
		if (n_fail == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Every command kind at least once, with bank, auto precharge and chop fields.
	task automatic t_decode;
		for (int i = 0; i < 12; i++) begin
			bnk = (i == 0) ? 0 : 2;
			dcd_ctrl_model_inst.send(1'b1, ks[i], bnk[2:0], ka[i]);
			dcd_ctrl_model_inst.nop(1);
			chk(cmd_valid_o, 1'b1);
			chk(cmd_code_o, kc[i]);
			chk(cmd_bank_o, bnk[2:0]);
			chk(auto_pre_o, ka[i][10] && ks[i][2:1] == 2'h2);
			if (ks[i][2:1] == 2'h2)
				chk(chop_o, !ka[i][12]);
			dcd_ctrl_model_inst.nop(40);
		end
		chk(burst_mode_o, `DCD_BURST_ON_THE_FLY);
	endtask

	// Self refresh entry from idle, hold, asynchronous exit and exit time before idle.
	task automatic t_sr;
		dcd_ctrl_model_inst.send(1'b0, 3'h1, ~ba, ~addr);
		dcd_ctrl_model_inst.nop(1);
		chk(power_state_o, 4'h8);
		chk(cmd_code_o, `DCD_CMD_SRE);
		dcd_ctrl_model_inst.nop(4);
		chk(power_state_o, 4'h8);
		chk(self_refresh_o, 1'b1);
		dcd_ctrl_model_inst.nop_cmd(1'b1);
		#1 chk(self_refresh_o, 1'b0);
		dcd_ctrl_model_inst.nop(1);
		chk(power_state_o, 4'h1);
		chk(cmd_code_o, `DCD_CMD_SRX);
		chk(idle_o, 1'b0);
		dcd_ctrl_model_inst.nop(40);
		chk(idle_o, 1'b1);
	endtask

	// Active and precharge power-down, entered and left with no-operation.
	task automatic t_pd;
		dcd_ctrl_model_inst.send(1'b1, 3'h3, 3'h5, 16'h0000);
		dcd_ctrl_model_inst.nop(5);
		chk(banks_open_o, 8'h20);
		for (int i = 0; i < 2; i++) begin
			dcd_ctrl_model_inst.nop_cmd(1'b0);
			dcd_ctrl_model_inst.nop(1);
			chk(power_state_o, i ? 4'h2 : 4'h4);
			chk(cmd_code_o, `DCD_CMD_PDE);
			chk(illegal_o, 1'b0);
			dcd_ctrl_model_inst.nop(3);
			chk(power_state_o, i ? 4'h2 : 4'h4);
			dcd_ctrl_model_inst.nop_cmd(1'b1);
			dcd_ctrl_model_inst.nop(1);
			chk(power_state_o, 4'h1);
			chk(cmd_code_o, `DCD_CMD_PDX);
			chk(illegal_o, 1'b0);
			dcd_ctrl_model_inst.send(1'b1, 3'h2, ~ba, addr | 16'h0400);
			dcd_ctrl_model_inst.nop(8);
		end
		chk(banks_open_o, 8'h00);
	endtask

	// No-operation and deselect during a burst leave the burst running.
	task automatic t_burst;
		dcd_ctrl_model_inst.send(1'b1, 3'h5, 3'h1, 16'h0000);
		dcd_ctrl_model_inst.nop_cmd(1'b1);
		dcd_ctrl_model_inst.nop(1);
		chk(cmd_valid_o, 1'b0);
		chk(burst_busy_o, 1'b1);
		dcd_ctrl_model_inst.nop(1);
		chk(cmd_valid_o, 1'b0);
		chk(burst_busy_o, 1'b1);
		dcd_ctrl_model_inst.nop(20);
	endtask

	// Row and column widths per organisation.
	task automatic t_org;
		for (int o = 0; o < 3; o++) begin
			@(negedge clk_sys_i);
			cfg_org_i = o[1:0];
			dcd_ctrl_model_inst.send(1'b1, 3'h3, 3'h0, 16'hFFFF);
			dcd_ctrl_model_inst.nop(1);
			chk(cmd_row_o, (o == 2) ? 16'h7FFF : 16'hFFFF);
			dcd_ctrl_model_inst.send(1'b1, 3'h5, 3'h0, 16'h0BFF);
			dcd_ctrl_model_inst.nop(1);
			chk(cmd_col_o, (o == 0) ? 11'h7FF : 11'h3FF);
			dcd_ctrl_model_inst.nop(10);
		end
	endtask

	// Device reset in mid-run acts without a clock edge, then commands resume.
	task automatic t_async;
		@(negedge clk_sys_i);
		reset_n_i = 1'b0;
		#1 chk(banks_open_o, 8'h00);
		chk(power_state_o, 4'h1);
		@(negedge clk_sys_i);
		reset_n_i = 1'b1;
		dcd_ctrl_model_inst.nop(3);
		dcd_ctrl_model_inst.send(1'b1, 3'h3, 3'h1, ~addr);
		dcd_ctrl_model_inst.nop(1);
		chk(cmd_code_o, `DCD_CMD_ACT);
	endtask

	////////////////////////////////////////////////////////////////////////////////

	// Cuts a hang short.
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 8000) begin
			n_fail++;
			complete_run;
		end
	end

	// Main sequence; the device reset stays high while commands flow.
	initial begin
		n_fail = 0;
		total_checks = 0;
		cycles = 0;
		cfg_org_i = 2'h2;
		rst_i = 1'b1;
		reset_n_i = 1'b1;
		repeat (16) @(negedge clk_sys_i);
		rst_i = 1'b0;
		dcd_ctrl_model_inst.nop(3);
		chk(power_state_o, 4'h1);
		t_decode;
		t_sr;
		t_pd;
		t_burst;
		t_org;
		t_async;
		complete_run;
	end
endmodule
